/* File: src/pmt_defines.vh */
`ifndef PMT_DEFINES_VH
`define PMT_DEFINES_VH
// register byte offsets, instance n at base n*0x10
`define PMT_INST_STRIDE 8'h10
`define PMT_OFF_CTRL 4'h0
`define PMT_OFF_COUNT 4'h4
`define PMT_OFF_PERIOD 4'h8
`define PMT_OFF_STATUS 4'hC
`define PMT_NUM_INST 2'h3
// control field positions
`define PMT_CKPS_LSB 0
`define PMT_ON_BIT 2
`define PMT_OUTPS_LSB 3
// status register fields
`define PMT_FLAG_BIT 0
`define PMT_IE_BIT 1
`define PMT_SSP_SEL_BIT 2
// reset values
`define PMT_CTRL_RST 7'h00
`define PMT_COUNT_RST 8'h00
`define PMT_PERIOD_RST 8'hFF
// instruction clock divider: fosc / 4
`define PMT_INSTR_DIV 2'h3
`endif

/* File: src/pmt_period_match_timer8.v */
`include "pmt_defines.vh"
module pmt_period_match_timer8 (
    input wire hclk,
    input wire hresetn,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg [31:0] hrdata,
    output reg hreadyout,
    output reg hresp,
    output reg [2:0] match_out,
    output reg [2:0] match_irq,
    output reg [2:0] ssp_shift_clk
);
    ////////////////////////////////////////////////////////////////////
    // instruction clock
    reg [1:0] div_q;
    reg instr_tick_q;
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            div_q <= 2'h0;
        else
            div_q <= div_q + 2'h1;
    end

    // tick once every four clocks
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            instr_tick_q <= 1'b0;
        else
            instr_tick_q <= (div_q == `PMT_INSTR_DIV);
    end

    ////////////////////////////////////////////////////////////////////
    // bus slave
    wire [7:0] a_addr;
    wire a_hi_ok;
    wire size_ok;
    wire take;
    wire wr_en;

    // transfer taken at the end of its address phase
    assign take = hsel && hready && htrans[1];
    assign a_addr = haddr[7:0];
    assign a_hi_ok = (haddr[31:8] == 24'h000000);
    assign size_ok = (hsize == 3'h2);
    assign wr_en = take && hwrite && a_hi_ok && size_ok;

    function [1:0] inst_of;
        input [7:0] a;
        begin
            inst_of = a[5:4];
        end
    endfunction

    function hit;
        input [7:0] a;
        begin
            hit = (a[7:6] == 2'h0) && (a[5:4] < `PMT_NUM_INST)
                && (a[1:0] == 2'h0);
        end
    endfunction

    // write strobe for one register of one instance
    function wr_strobe;
        input en;
        input [7:0] a;
        input [1:0] inst;
        input [3:0] off;
        begin
            wr_strobe = en && hit(a) && (inst_of(a) == inst)
                && (a[3:0] == off);
        end
    endfunction

    // instance number as a two-bit code
    function [1:0] idx_of;
        input integer i;
        begin
            idx_of = i[1:0];
        end
    endfunction

    // zero wait states
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            hreadyout <= 1'b1;
        else
            hreadyout <= 1'b1;
    end

    // response always okay
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            hresp <= 1'b0;
        else
            hresp <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////
    // per-instance registers and timers
    wire [31:0] rd_w [0:2];
    wire [7:0] cnt_w [0:2];
    wire [7:0] per_w [0:2];
    wire [2:0] post_w;
    wire [2:0] mt_w;
    wire [2:0] irq_w;
    wire [2:0] ssp_w;
    genvar g;

    generate
        for (g = 0; g < 3; g = g + 1)
        begin : inst
            wire [1:0] idx;
            reg cw_q;
            reg kw_q;
            reg pw_q;
            reg sw_q;
            reg [6:0] ctrl_q;
            reg flag_q;
            reg ie_q;
            reg ssp_sel_q;
            reg [31:0] rv;
            assign idx = idx_of(g);

            // control write strobe
            always @(posedge hclk or negedge hresetn)
            begin
                if (!hresetn)
                begin
                    cw_q <= 1'b0;
                end
                else
                begin
                    cw_q <= wr_strobe(wr_en, a_addr, idx, `PMT_OFF_CTRL);
                end
            end

            // count write strobe
            always @(posedge hclk or negedge hresetn)
            begin
                if (!hresetn)
                begin
                    kw_q <= 1'b0;
                end
                else
                begin
                    kw_q <= wr_strobe(wr_en, a_addr, idx, `PMT_OFF_COUNT);
                end
            end

            // period write strobe
            always @(posedge hclk or negedge hresetn)
            begin
                if (!hresetn)
                begin
                    pw_q <= 1'b0;
                end
                else
                begin
                    pw_q <= wr_strobe(wr_en, a_addr, idx, `PMT_OFF_PERIOD);
                end
            end

            // status write strobe
            always @(posedge hclk or negedge hresetn)
            begin
                if (!hresetn)
                begin
                    sw_q <= 1'b0;
                end
                else
                begin
                    sw_q <= wr_strobe(wr_en, a_addr, idx, `PMT_OFF_STATUS);
                end
            end

            always @(posedge hclk or negedge hresetn)
            begin
                if (!hresetn)
                begin
                    ctrl_q <= `PMT_CTRL_RST;
                end
                else if (cw_q)
                begin
                    ctrl_q <= hwdata[6:0];
                end
            end

            // sticky flag, set wins over clear
            always @(posedge hclk or negedge hresetn)
            begin
                if (!hresetn)
                    flag_q <= 1'b0;
                else if (post_w[g])
                    flag_q <= 1'b1;
                else if (sw_q && !hwdata[`PMT_FLAG_BIT])
                    flag_q <= 1'b0;
            end

            // interrupt enable bit
            always @(posedge hclk or negedge hresetn)
            begin
                if (!hresetn)
                begin
                    ie_q <= 1'b0;
                end
                else if (sw_q)
                begin
                    ie_q <= hwdata[`PMT_IE_BIT];
                end
            end

            always @(posedge hclk or negedge hresetn)
            begin
                if (!hresetn)
                begin
                    ssp_sel_q <= 1'b0;
                end
                else if (sw_q)
                begin
                    ssp_sel_q <= hwdata[`PMT_SSP_SEL_BIT];
                end
            end

            // read view of this instance
            always @*
            begin
                rv = 32'h00000000;
                case (a_addr[3:0])
                    `PMT_OFF_CTRL: rv = {25'h0, ctrl_q};
                    `PMT_OFF_COUNT: rv = {24'h0, cnt_w[g]};
                    `PMT_OFF_PERIOD: rv = {24'h0, per_w[g]};
                    `PMT_OFF_STATUS: rv = {29'h0, ssp_sel_q, ie_q, flag_q};
                    default: rv = 32'h00000000;
                endcase
            end
            assign rd_w[g] = rv;

            assign irq_w[g] = flag_q & ie_q;
            assign ssp_w[g] = mt_w[g] & ssp_sel_q;

            pmt_timer u_tmr (
                .hclk(hclk),
                .hresetn(hresetn),
                .instr_tick(instr_tick_q),
                .timer_control(ctrl_q),
                .ctrl_wr(cw_q),
                .count_wr(kw_q),
                .period_wr(pw_q),
                .wdata(hwdata[7:0]),
                .timer_count_q(cnt_w[g]),
                .period_value_q(per_w[g]),
                .match_q(mt_w[g]),
                .post_tick_q(post_w[g])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////
    // output flops
    // match pulse out
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            match_out <= 3'h0;
        end
        else
        begin
            match_out <= mt_w;
        end
    end

    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            match_irq <= 3'h0;
        end
        else
        begin
            match_irq <= irq_w;
        end
    end

    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ssp_shift_clk <= 3'h0;
        end
        else
        begin
            ssp_shift_clk <= ssp_w;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // read data
    reg [31:0] rd_d;
    always @*
    begin
        rd_d = 32'h00000000;
        if (a_hi_ok && size_ok && hit(a_addr))
            rd_d = rd_w[inst_of(a_addr)];
    end

    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            hrdata <= 32'h00000000;
        else if (take && !hwrite)
            hrdata <= rd_d;
    end
endmodule

/* File: src/pmt_timer.v */
`include "pmt_defines.vh"
module pmt_timer (
    input wire hclk,
    input wire hresetn,
    input wire instr_tick,
    input wire [6:0] timer_control,
    input wire ctrl_wr,
    input wire count_wr,
    input wire period_wr,
    input wire [7:0] wdata,
    output reg [7:0] timer_count_q,
    output reg [7:0] period_value_q,
    output reg match_q,
    output reg post_tick_q
);
    reg [5:0] pre_q;
    reg [3:0] post_q;
    wire [1:0] ckps;
    wire [3:0] outps;
    wire on;
    wire pre_out;
    assign ckps = timer_control[`PMT_CKPS_LSB +: 2];
    assign outps = timer_control[`PMT_OUTPS_LSB +: 4];
    assign on = timer_control[`PMT_ON_BIT];
    function [5:0] pre_max;
        input [1:0] sel;
        begin
            case (sel)
                2'h0: pre_max = 6'h00;
                2'h1: pre_max = 6'h03;
                2'h2: pre_max = 6'h0F;
                default: pre_max = 6'h3F;
            endcase
        end
    endfunction
    assign pre_out = instr_tick && on && (pre_q >= pre_max(ckps));
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            pre_q <= 6'h00;
            post_q <= 4'h0;
            post_tick_q <= 1'b0;
        end
        else if (ctrl_wr || count_wr)
        begin
            pre_q <= 6'h00;
            post_q <= 4'h0;
            post_tick_q <= 1'b0;
        end
        else
        begin
            post_tick_q <= 1'b0;
            if (instr_tick && on)
                pre_q <= pre_out ? 6'h00 : pre_q + 6'h01;
            if (match_q)
            begin
                if (post_q >= outps)
                begin
                    post_q <= 4'h0;
                    post_tick_q <= 1'b1;
                end
                else
                    post_q <= post_q + 4'h1;
            end
        end
    end
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            timer_count_q <= `PMT_COUNT_RST;
            period_value_q <= `PMT_PERIOD_RST;
            match_q <= 1'b0;
        end
        else
        begin
            match_q <= 1'b0;
            if (period_wr)
                period_value_q <= wdata;
            if (count_wr)
                timer_count_q <= wdata;
            else if (pre_out)
            begin
                if (timer_count_q == period_value_q)
                begin
                    timer_count_q <= 8'h00;
                    match_q <= 1'b1;
                end
                else
                    timer_count_q <= timer_count_q + 8'h01;
            end
        end
    end
endmodule

/* File: test/pmt_chk.sv */
module pmt_chk (
    input logic hclk,
    input logic hresetn,
    input logic hsel,
    input logic [31:0] haddr,
    input logic [1:0] htrans,
    input logic hwrite,
    input logic [2:0] hsize,
    input logic [31:0] hwdata,
    input logic hready,
    input logic [31:0] hrdata,
    input logic hreadyout,
    input logic hresp,
    input logic [2:0] match_out,
    input logic [2:0] match_irq,
    input logic [2:0] ssp_shift_clk
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    logic rd_take, wr_take, wa_q, on_q;
    logic [3:0] quiet_q;
    assign rd_take = hsel && hready && htrans[1] && !hwrite;
    assign wr_take = hsel && hready && htrans[1] && hwrite;
    ////////////////////////////////////////
    // shadow of instance 0 timer_on, quiet count
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wa_q <= 1'b0;
            on_q <= 1'b0;
            quiet_q <= 4'h0;
        end
        else
        begin
            wa_q <= wr_take && (haddr == 32'h0);
            if (wa_q)
                on_q <= hwdata[2];
            if (match_out != 3'h0 || wr_take)
                quiet_q <= 4'h0;
            else if (quiet_q != 4'hF)
                quiet_q <= quiet_q + 4'h1;
        end
    end
    ////////////////////////////////////////
    property p_ready; hreadyout && !hresp; endproperty
    a_ready: assert property (p_ready) else $error("not ready or not okay");
    property p_ssp; (ssp_shift_clk & ~match_out) == 3'h0; endproperty
    a_ssp: assert property (p_ssp) else $error("shift clock without match");
    property p_gap; match_out[0] |=> (match_out[0] == 1'b0) [*3]; endproperty
    a_gap: assert property (p_gap) else $error("match closer than 4 cycles");
    property p_hold; !$past(rd_take) |-> $stable(hrdata); endproperty
    a_hold: assert property (p_hold) else $error("read data moved");
    property p_unmap; rd_take && haddr >= 32'h30 |=> hrdata == 32'h0; endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read not 0");
    property p_irq; $changed(match_irq) |-> quiet_q < 4'h6; endproperty
    a_irq: assert property (p_irq) else $error("irq moved without cause");
    property p_off; (on_q == 1'b0) [*8] |-> !match_out[0]; endproperty
    a_off: assert property (p_off) else $error("match while off");
    property p_post; match_out[0] |-> !$past(match_out[0]); endproperty
    a_post: assert property (p_post) else $error("match pulse too long");
    c_irq: cover property (match_irq[1]);
    c_ssp: cover property (ssp_shift_clk[1]);
    c_unmap: cover property (rd_take && haddr >= 32'h30);
endmodule

bind pmt_period_match_timer8 pmt_chk pmt_chk_u (.hclk, .hresetn, .hsel,
    .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hrdata,
    .hreadyout, .hresp, .match_out, .match_irq, .ssp_shift_clk);

/* File: test/pmt_period_match_timer8_tb.sv */
module pmt_period_match_timer8_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic hclk = 0, hresetn = 0, hwrite = 0, rd_dp = 0;
    logic [31:0] haddr = 0, hwdata = 0, hrdata;
    logic [1:0] htrans = 0;
    logic hreadyout, hresp;
    logic [2:0] match_out, match_irq, ssp_shift_clk;
    logic [31:0] expq[$];
    logic [31:0] pv[3], cv[3];
    int fails = 0, compares = 0, cyc = 0, n, m, k;
    pmt_period_match_timer8 dut_u (.hclk(hclk), .hresetn(hresetn),
        .hsel(1'b1), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .match_out(match_out), .match_irq(match_irq),
        .ssp_shift_clk(ssp_shift_clk));
    initial
    begin
        forever #10 hclk = ~hclk;
    end
    ////////////////////////////////////////
    task end_of_test;
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e)
        begin
            fails++;
            $display("mismatch %s exp %h got %h", nm, e, g);
        end
    endtask
    task bus(input int a, input logic w, input logic [31:0] d, e);
        @(posedge hclk);
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        if (!w)
            expq.push_back(e);
        rd_dp <= !w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd_dp <= 1'b0;
    endtask
    task gap(input int b);
        do @(negedge hclk); while (match_out[b] !== 1'b1);
        n = 0;
        do
        begin
            @(negedge hclk);
            n++;
        end while (match_out[b] !== 1'b1);
    endtask
    ////////////////////////////////////////
    // read results checked as they appear
    always @(posedge hclk)
    begin
        cyc++;
        if (cyc == 40000)
        begin
            fails++;
            end_of_test;
        end
        if (rd_dp && hreadyout === 1'b1)
            chk("hrdata", expq.pop_front(), hrdata);
    end
    initial
    begin
        void'($urandom(87));
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        for (k = 0; k < 3; k++)
        begin
            bus(k * 16, 0, 0, 0);
            bus(k * 16 + 4, 0, 0, 0);
            bus(k * 16 + 8, 0, 0, 32'hFF);
            pv[k] = $urandom & 255;
            cv[k] = $urandom & 255;
            bus(k * 16 + 8, 1, pv[k], 0);
            bus(k * 16 + 4, 1, cv[k], 0);
        end
        for (k = 0; k < 3; k++)
        begin
            bus(k * 16, 1, 32'h78, 0);
            bus(k * 16 + 4, 0, 0, cv[k]);
            bus(k * 16 + 8, 0, 0, pv[k]);
            bus(k * 16, 0, 0, 32'h78);
        end
        bus(32'h30, 0, 0, 0);
        for (k = 0; k < 4; k++)
        begin
            bus(8, 1, 2, 0);
            bus(0, 1, 4 | k, 0);
            gap(0);
            gap(0);
            chk("gap", 12 * (1 << (2 * k)), n);
            bus(0, 1, 0, 0);
        end
        bus(24, 1, 1, 0);
        bus(28, 1, 6, 0);
        for (k = 0; k < 3; k++)
        begin
            bus(16, 1, (((1 << (2 * k)) - 1) << 3) | 4, 0);
            n = 0;
            m = 0;
            while (match_irq[1] !== 1'b1)
            begin
                @(negedge hclk);
                if (match_out[1] === 1'b1)
                    n++;
                if (ssp_shift_clk[1] === 1'b1)
                    m++;
            end
            chk("post", 1 << (2 * k), n);
            chk("ssp", 1 << (2 * k), m);
            bus(16, 1, 0, 0);
            bus(28, 0, 0, 7);
            bus(28, 1, 6, 0);
            bus(28, 0, 0, 6);
        end
        end_of_test;
    end
endmodule
